/* logic/pin_mux_pkg.sv */
// Package with register map, field positions and reset values of the port pin mux
package pin_mux_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_PORT_ZERO_DATA = 8'h00;
    localparam logic [7:0] OFF_PORT_ZERO_MODE = 8'h04;
    localparam logic [7:0] OFF_PORT_ONE_DATA = 8'h08;
    localparam logic [7:0] OFF_PORT_ONE_MODE = 8'h0c;
    localparam logic [7:0] OFF_PORT_TWO_DATA = 8'h10;
    localparam logic [7:0] OFF_PORT_TWO_MODE = 8'h14;
    localparam logic [7:0] OFF_PORT_FOUR_DATA = 8'h18;
    localparam logic [7:0] OFF_PORT_FOUR_MODE = 8'h1c;
    localparam logic [7:0] OFF_PORT_SIX_DATA = 8'h20;
    localparam logic [7:0] OFF_PORT_SIX_MODE = 8'h24;
    localparam logic [7:0] OFF_PORT_EIGHT_DATA = 8'h28;
    localparam logic [7:0] OFF_PORT_EIGHT_MODE = 8'h2c;
    localparam logic [7:0] OFF_PORT_PULLUP = 8'h30;
    localparam logic [7:0] OFF_SERIAL_PULLUP = 8'h34;
    localparam logic [7:0] OFF_KEY_RETURN_MODE = 8'h38;
    localparam logic [7:0] OFF_ALT_CTRL = 8'h3c;
    localparam logic [7:0] OFF_PORT_EIGHT_FUNC = 8'h40;
    // Port pull-up select fields
    localparam int PU_PORT_ZERO_BIT = 0;
    localparam int PU_PORT_ONE_BIT = 1;
    localparam int PU_PORT_FOUR_BIT = 2;
    // Alternate control fields
    localparam int ALT_SER_EN_BIT = 0;
    localparam int ALT_TIMER_EN_BIT = 1;
    localparam int ALT_EDGE_LSB = 2;
    localparam int ALT_LCD_ON_BIT = 4;
    // Valid edge encodings of the external interrupt
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISING = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Reset values
    localparam logic [7:0] RST_MODE = 8'hff;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
endpackage

/* logic/edge_detect.sv */
// Edge detector with selectable valid edge, ORed over a group of inputs
`timescale 1ns/1ps
module edge_detect
    import pin_mux_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Levels and edge choice
    input wire logic [W-1:0] level_in,
    input wire logic [1:0] edge_sel,
    // Detection
    output logic pulse_q
);
    logic [W-1:0] prev_q;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    assign rise = level_in & ~prev_q;
    assign fall = ~level_in & prev_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= '0;
        end else begin
            prev_q <= level_in;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= (edge_sel[0] & (|rise)) | (edge_sel[1] & (|fall));
        end
    end
endmodule

/* logic/port_cell.sv */
// One general-purpose port: output latch, per-bit mode, alternate mux and pull-up
`timescale 1ns/1ps
module port_cell
    import pin_mux_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register writes
    input wire logic data_we,
    input wire logic mode_we,
    input wire logic [7:0] wdata,
    // Alternate function
    input wire logic [W-1:0] alt_sel,
    input wire logic [W-1:0] alt_out,
    input wire logic [W-1:0] alt_oe,
    input wire logic [W-1:0] pu_req,
    // Pin side
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out_q,
    output logic [W-1:0] pin_oe_q,
    output logic [W-1:0] pin_pu_q,
    // Read back
    output logic [W-1:0] mode_q,
    output logic [W-1:0] rd_value
);
    logic [W-1:0] latch_q;
    logic [W-1:0] oe_d;

    // Mode bit high means input
    assign oe_d = (alt_sel & alt_oe) | (~alt_sel & ~mode_q);
    assign rd_value = (mode_q & pin_in) | (~mode_q & latch_q);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_q <= RST_LATCH[W-1:0];
        end else if (data_we) begin
            latch_q <= wdata[W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= RST_MODE[W-1:0];
        end else if (mode_we) begin
            mode_q <= wdata[W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
            pin_pu_q <= '0;
        end else begin
            pin_out_q <= (alt_sel & alt_out) | (~alt_sel & latch_q);
            pin_oe_q <= oe_d;
            // Pull-up only where the pin is not driven
            pin_pu_q <= pu_req & ~oe_d;
        end
    end
endmodule

/* logic/port_pin_mux.sv */
// Top of the port and pin-sharing logic with its Wishbone register slave
// What this block does
// - Ports zero and four are four-bit bidirectional ports, readable and drivable.
// - Ports one and six are two-bit bidirectional ports.
// - Port two is three bits, shared with serial clock, output and input.
// - Port eight is six bits, shared with six LCD segment outputs.
// - Each port bit has its own input or output direction.
// - Ports zero, one, four: one pull-up setting per port, inputs only.
// - Port two pull-up is chosen per bit.
// - Port four pull-up on when port pull-up or key-return mode asks.
// - External interrupt on port six bit one: rising, falling or both edges.
// - Port four pins double as key-return inputs, same order.
// - Port six bit zero can carry the timer forty output.
// - Serial clock on port two bit zero is bidirectional; out bit one, in bit two.
// - Port eight bit i carries segment twenty-two minus i.
// - Four common outputs, low after reset.
// - Each port eight bit switches between port and segment individually.
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module port_pin_mux
    import pin_mux_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Port zero
    input wire logic [3:0] PORT_ZERO_PINS_IN,
    output logic [3:0] PORT_ZERO_PINS_OUT,
    output logic [3:0] PORT_ZERO_PINS_OE,
    output logic [3:0] PORT_ZERO_PINS_PU,
    // Port one
    input wire logic [1:0] PORT_ONE_PINS_IN,
    output logic [1:0] PORT_ONE_PINS_OUT,
    output logic [1:0] PORT_ONE_PINS_OE,
    output logic [1:0] PORT_ONE_PINS_PU,
    // Port two
    input wire logic [2:0] PORT_TWO_PINS_IN,
    output logic [2:0] PORT_TWO_PINS_OUT,
    output logic [2:0] PORT_TWO_PINS_OE,
    output logic [2:0] PORT_TWO_PINS_PU,
    // Port four
    input wire logic [3:0] PORT_FOUR_PINS_IN,
    output logic [3:0] PORT_FOUR_PINS_OUT,
    output logic [3:0] PORT_FOUR_PINS_OE,
    output logic [3:0] PORT_FOUR_PINS_PU,
    // Port six
    input wire logic [1:0] PORT_SIX_PINS_IN,
    output logic [1:0] PORT_SIX_PINS_OUT,
    output logic [1:0] PORT_SIX_PINS_OE,
    output logic [1:0] PORT_SIX_PINS_PU,
    // Port eight
    input wire logic [5:0] PORT_EIGHT_PINS_IN,
    output logic [5:0] PORT_EIGHT_PINS_OUT,
    output logic [5:0] PORT_EIGHT_PINS_OE,
    output logic [5:0] PORT_EIGHT_PINS_PU,
    // Serial unit
    input wire logic SER_CLK_OUT,
    input wire logic SER_CLK_DRIVE,
    input wire logic SER_DATA_OUT,
    output logic SER_CLK_IN,
    output logic SER_DATA_IN,
    // Timer and interrupt
    input wire logic TIMER_FORTY_OUT,
    output logic INT_EDGE_PULSE,
    // Key return
    output logic [3:0] KEY_RETURN_INPUTS,
    output logic KEY_RETURN_PULSE,
    // LCD driver
    input wire logic [16:0] LCD_SEG_DEDICATED_IN,
    input wire logic LCD_SEG_LAST_IN,
    input wire logic [5:0] LCD_SEG_SHARED_IN,
    input wire logic [3:0] LCD_COMMON_IN,
    output logic [16:0] LCD_SEG_DEDICATED,
    output logic LCD_SEG_LAST,
    output logic [3:0] LCD_COMMON_OUTS
);
    logic [2:0] port_pullup_select_q;
    logic [2:0] serial_port_bit_pullup_q;
    logic key_return_mode_setting_q;
    logic [4:0] alt_ctrl_q;
    logic [5:0] port_eight_function_select_q;
    logic wr_fire;
    logic rd_fire;
    logic [3:0] m0, r0, m4, r4;
    logic [1:0] m1, r1, m6, r6;
    logic [2:0] m2, r2;
    logic [5:0] m8, r8, seg_rev;
    logic ser_en, timer_en, lcd_on;
    logic [1:0] edge_sel;
    logic [31:0] rd_d;

    // Register decode
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction

    // Write lands at the edge where the master sees ack
    assign wr_fire = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & WB_SEL_I[0];
    assign rd_fire = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign ser_en = alt_ctrl_q[ALT_SER_EN_BIT];
    assign timer_en = alt_ctrl_q[ALT_TIMER_EN_BIT];
    assign edge_sel = alt_ctrl_q[ALT_EDGE_LSB +: 2];
    assign lcd_on = alt_ctrl_q[ALT_LCD_ON_BIT];

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= rd_fire;
        end
    end

    always_comb begin
        rd_d = '0;
        case (WB_ADR_I)
            OFF_PORT_ZERO_DATA: rd_d[3:0] = r0;
            OFF_PORT_ZERO_MODE: rd_d[3:0] = m0;
            OFF_PORT_ONE_DATA: rd_d[1:0] = r1;
            OFF_PORT_ONE_MODE: rd_d[1:0] = m1;
            OFF_PORT_TWO_DATA: rd_d[2:0] = r2;
            OFF_PORT_TWO_MODE: rd_d[2:0] = m2;
            OFF_PORT_FOUR_DATA: rd_d[3:0] = r4;
            OFF_PORT_FOUR_MODE: rd_d[3:0] = m4;
            OFF_PORT_SIX_DATA: rd_d[1:0] = r6;
            OFF_PORT_SIX_MODE: rd_d[1:0] = m6;
            OFF_PORT_EIGHT_DATA: rd_d[5:0] = r8;
            OFF_PORT_EIGHT_MODE: rd_d[5:0] = m8;
            OFF_PORT_PULLUP: rd_d[2:0] = port_pullup_select_q;
            OFF_SERIAL_PULLUP: rd_d[2:0] = serial_port_bit_pullup_q;
            OFF_KEY_RETURN_MODE: rd_d[0] = key_return_mode_setting_q;
            OFF_ALT_CTRL: rd_d[4:0] = alt_ctrl_q;
            OFF_PORT_EIGHT_FUNC: rd_d[5:0] = port_eight_function_select_q;
            default: rd_d = '0;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            WB_DAT_O <= '0;
        end else if (rd_fire) begin
            WB_DAT_O <= rd_d;
        end
    end

    // Control registers
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            port_pullup_select_q <= RST_CTRL[2:0];
            serial_port_bit_pullup_q <= RST_CTRL[2:0];
            key_return_mode_setting_q <= RST_CTRL[0];
            alt_ctrl_q <= RST_CTRL[4:0];
            port_eight_function_select_q <= RST_CTRL[5:0];
        end else if (wr_fire) begin
            if (hit(WB_ADR_I, OFF_PORT_PULLUP)) begin
                port_pullup_select_q <= WB_DAT_I[2:0];
            end
            if (hit(WB_ADR_I, OFF_SERIAL_PULLUP)) begin
                serial_port_bit_pullup_q <= WB_DAT_I[2:0];
            end
            if (hit(WB_ADR_I, OFF_KEY_RETURN_MODE)) begin
                key_return_mode_setting_q <= WB_DAT_I[0];
            end
            if (hit(WB_ADR_I, OFF_ALT_CTRL)) begin
                alt_ctrl_q <= WB_DAT_I[4:0];
            end
            if (hit(WB_ADR_I, OFF_PORT_EIGHT_FUNC)) begin
                port_eight_function_select_q <= WB_DAT_I[5:0];
            end
        end
    end

    port_cell #(.W(4)) u_port_zero (
        .clk(CORE_CLK), .nrst(NRST),
        .data_we(wr_fire & hit(WB_ADR_I, OFF_PORT_ZERO_DATA)),
        .mode_we(wr_fire & hit(WB_ADR_I, OFF_PORT_ZERO_MODE)),
        .wdata(WB_DAT_I[7:0]), .alt_sel(4'h0), .alt_out(4'h0), .alt_oe(4'h0),
        .pu_req({4{port_pullup_select_q[PU_PORT_ZERO_BIT]}}),
        .pin_in(PORT_ZERO_PINS_IN), .pin_out_q(PORT_ZERO_PINS_OUT), .pin_oe_q(PORT_ZERO_PINS_OE),
        .pin_pu_q(PORT_ZERO_PINS_PU), .mode_q(m0), .rd_value(r0)
    );

    port_cell #(.W(2)) u_port_one (
        .clk(CORE_CLK), .nrst(NRST),
        .data_we(wr_fire & hit(WB_ADR_I, OFF_PORT_ONE_DATA)),
        .mode_we(wr_fire & hit(WB_ADR_I, OFF_PORT_ONE_MODE)),
        .wdata(WB_DAT_I[7:0]), .alt_sel(2'h0), .alt_out(2'h0), .alt_oe(2'h0),
        .pu_req({2{port_pullup_select_q[PU_PORT_ONE_BIT]}}),
        .pin_in(PORT_ONE_PINS_IN), .pin_out_q(PORT_ONE_PINS_OUT), .pin_oe_q(PORT_ONE_PINS_OE),
        .pin_pu_q(PORT_ONE_PINS_PU), .mode_q(m1), .rd_value(r1)
    );

    // Serial: clock drive follows the serial unit, data in never driven
    port_cell #(.W(3)) u_port_two (
        .clk(CORE_CLK), .nrst(NRST),
        .data_we(wr_fire & hit(WB_ADR_I, OFF_PORT_TWO_DATA)),
        .mode_we(wr_fire & hit(WB_ADR_I, OFF_PORT_TWO_MODE)),
        .wdata(WB_DAT_I[7:0]), .alt_sel({3{ser_en}}),
        .alt_out({1'b0, SER_DATA_OUT, SER_CLK_OUT}), .alt_oe({1'b0, 1'b1, SER_CLK_DRIVE}),
        .pu_req(serial_port_bit_pullup_q),
        .pin_in(PORT_TWO_PINS_IN), .pin_out_q(PORT_TWO_PINS_OUT), .pin_oe_q(PORT_TWO_PINS_OE),
        .pin_pu_q(PORT_TWO_PINS_PU), .mode_q(m2), .rd_value(r2)
    );

    // Key-return mode forces inputs so the keys are never fought
    port_cell #(.W(4)) u_port_four (
        .clk(CORE_CLK), .nrst(NRST),
        .data_we(wr_fire & hit(WB_ADR_I, OFF_PORT_FOUR_DATA)),
        .mode_we(wr_fire & hit(WB_ADR_I, OFF_PORT_FOUR_MODE)),
        .wdata(WB_DAT_I[7:0]), .alt_sel({4{key_return_mode_setting_q}}), .alt_out(4'h0), .alt_oe(4'h0),
        .pu_req({4{port_pullup_select_q[PU_PORT_FOUR_BIT] | key_return_mode_setting_q}}),
        .pin_in(PORT_FOUR_PINS_IN), .pin_out_q(PORT_FOUR_PINS_OUT), .pin_oe_q(PORT_FOUR_PINS_OE),
        .pin_pu_q(PORT_FOUR_PINS_PU), .mode_q(m4), .rd_value(r4)
    );

    port_cell #(.W(2)) u_port_six (
        .clk(CORE_CLK), .nrst(NRST),
        .data_we(wr_fire & hit(WB_ADR_I, OFF_PORT_SIX_DATA)),
        .mode_we(wr_fire & hit(WB_ADR_I, OFF_PORT_SIX_MODE)),
        .wdata(WB_DAT_I[7:0]), .alt_sel({1'b0, timer_en}),
        .alt_out({1'b0, TIMER_FORTY_OUT}), .alt_oe(2'h3), .pu_req(2'h0),
        .pin_in(PORT_SIX_PINS_IN), .pin_out_q(PORT_SIX_PINS_OUT), .pin_oe_q(PORT_SIX_PINS_OE),
        .pin_pu_q(PORT_SIX_PINS_PU), .mode_q(m6), .rd_value(r6)
    );

    // Segment order is reversed on port eight
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            seg_rev[i] = LCD_SEG_SHARED_IN[5-i];
        end
    end

    port_cell #(.W(6)) u_port_eight (
        .clk(CORE_CLK), .nrst(NRST),
        .data_we(wr_fire & hit(WB_ADR_I, OFF_PORT_EIGHT_DATA)),
        .mode_we(wr_fire & hit(WB_ADR_I, OFF_PORT_EIGHT_MODE)),
        .wdata(WB_DAT_I[7:0]), .alt_sel(port_eight_function_select_q),
        .alt_out(seg_rev), .alt_oe(6'h3f), .pu_req(6'h00),
        .pin_in(PORT_EIGHT_PINS_IN), .pin_out_q(PORT_EIGHT_PINS_OUT), .pin_oe_q(PORT_EIGHT_PINS_OE),
        .pin_pu_q(PORT_EIGHT_PINS_PU), .mode_q(m8), .rd_value(r8)
    );

    // Interrupt edge works in any port mode, the pin is always sampled
    edge_detect #(.W(1)) u_int_edge (
        .clk(CORE_CLK), .nrst(NRST), .level_in(PORT_SIX_PINS_IN[1]),
        .edge_sel(edge_sel), .pulse_q(INT_EDGE_PULSE)
    );

    // Keys pull a line low, so falling edges count
    edge_detect #(.W(4)) u_key_edge (
        .clk(CORE_CLK), .nrst(NRST), .level_in(PORT_FOUR_PINS_IN),
        .edge_sel(key_return_mode_setting_q ? EDGE_FALLING : EDGE_NONE),
        .pulse_q(KEY_RETURN_PULSE)
    );

    // Alternate inputs and LCD outputs
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            SER_CLK_IN <= 1'b0;
            SER_DATA_IN <= 1'b0;
            KEY_RETURN_INPUTS <= '0;
        end else begin
            SER_CLK_IN <= PORT_TWO_PINS_IN[0];
            SER_DATA_IN <= PORT_TWO_PINS_IN[2];
            KEY_RETURN_INPUTS <= PORT_FOUR_PINS_IN;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            LCD_SEG_DEDICATED <= '0;
            LCD_SEG_LAST <= 1'b0;
            LCD_COMMON_OUTS <= '0;
        end else begin
            LCD_SEG_DEDICATED <= lcd_on ? LCD_SEG_DEDICATED_IN : 17'h00000;
            LCD_SEG_LAST <= lcd_on & LCD_SEG_LAST_IN;
            LCD_COMMON_OUTS <= lcd_on ? LCD_COMMON_IN : 4'h0;
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    port_zero_dir_a: assert property (PORT_ZERO_PINS_OE == ~$past(m0))
        else $error("port zero drive does not follow its mode bits");
    port_zero_pu_a: assert property ((PORT_ZERO_PINS_PU & PORT_ZERO_PINS_OE) == 4'h0)
        else $error("pull-up active on a driven pin");
    port_four_pu_a: assert property ((key_return_mode_setting_q && m4 == 4'hf) |=> PORT_FOUR_PINS_PU == 4'hf)
        else $error("port four pull-up missing in key return mode");
    serial_map_a: assert property (ser_en |=> (PORT_TWO_PINS_OUT[1] == $past(SER_DATA_OUT)
        && PORT_TWO_PINS_OE[1] && !PORT_TWO_PINS_OE[2] && PORT_TWO_PINS_OE[0] == $past(SER_CLK_DRIVE)))
        else $error("serial pins not mapped");
    timer_route_a: assert property (timer_en |=> PORT_SIX_PINS_OE[0] && PORT_SIX_PINS_OUT[0] == $past(TIMER_FORTY_OUT))
        else $error("timer output not on port six bit zero");
    seg_reverse_a: assert property (port_eight_function_select_q[0] |=> PORT_EIGHT_PINS_OE[0]
        && PORT_EIGHT_PINS_OUT[0] == $past(LCD_SEG_SHARED_IN[5]))
        else $error("segment order wrong on port eight");
    int_edge_a: assert property ((edge_sel == EDGE_FALLING && $rose(PORT_SIX_PINS_IN[1])) |=> !INT_EDGE_PULSE)
        else $error("falling-only interrupt fired on a rise");
    int_rise_a: assert property ((edge_sel == EDGE_RISING && $rose(PORT_SIX_PINS_IN[1])) |=> INT_EDGE_PULSE)
        else $error("rising edge missed");
    common_low_a: assert property (!lcd_on |=> LCD_COMMON_OUTS == 4'h0 && LCD_SEG_DEDICATED == 17'h00000)
        else $error("LCD outputs not low while off");
    reset_inputs_a: assert property (@(posedge CORE_CLK) disable iff (1'b0) $rose(NRST) |->
        (PORT_EIGHT_PINS_OE == 6'h00 && PORT_ZERO_PINS_OE == 4'h0 && PORT_TWO_PINS_OE == 3'h0))
        else $error("port pins driven right after reset");

    int_pulse_c: cover property (edge_sel == EDGE_BOTH ##1 INT_EDGE_PULSE);
    key_pulse_c: cover property (key_return_mode_setting_q ##1 KEY_RETURN_PULSE);
    wb_write_c: cover property (WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O);
endmodule

/* dv/board_pins.sv */
// Board side of one port: pin level from chip drive, external drive and pull-up
`timescale 1ns/1ps
module board_pins #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] dout,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] drv,
    input wire logic [W-1:0] lvl,
    output logic [W-1:0] pin
);
    logic [W-1:0] last_q = '0;
    // Undriven pin with no pull-up toggles, so a floating read never looks stable
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = oe[i] ? dout[i] : drv[i] ? lvl[i] : pu[i] ? 1'b1 : ~last_q[i];
        end
    end
    always_ff @(posedge clk) begin
        last_q <= pin;
    end
endmodule

/* dv/port_pin_mux_tb.sv */
// Self-checking bench of the port pin mux over its Wishbone registers
`timescale 1ns/1ps
module port_pin_mux_tb;
    import pin_mux_pkg::*;
    logic clk = 1'b0, nrst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, int_p, key_p, sdi;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0] o0, e0, u0, n0, l0 = 4'h1, o4, e4, u4, n4, l4 = 4'hf, kin, com, com_in = 4'ha, d0 = 4'hf;
    logic [1:0] o1, e1, u1, n1, o6, e6, u6, n6, l6 = 2'h0, l1 = 2'h2;
    logic [2:0] o2, e2, u2, n2, l2 = 3'h4;
    logic [5:0] o8, e8, u8, n8, sh_in = 6'h01, drv = 6'h3f, l8 = 6'h15;
    logic [16:0] ded, ded_in = 17'h1a5a5;
    logic last, tmr = 1'b1, sck_o = 1'b1, sck_d = 1'b1, sdo = 1'b0, sck_in, seg_last = 1'b1;
    int num_errors = 0, checked = 0, int_cnt = 0, key_cnt = 0, c0;
    const int edge_exp[4] = '{0, 1, 1, 2};
    always #4 clk = ~clk;
    board_pins #(.W(4)) b0 (.clk(clk), .oe(e0), .dout(o0), .pu(u0), .drv(d0), .lvl(l0), .pin(n0));
    board_pins #(.W(2)) b1 (.clk(clk), .oe(e1), .dout(o1), .pu(u1), .drv(drv[1:0]), .lvl(l1), .pin(n1));
    board_pins #(.W(3)) b2 (.clk(clk), .oe(e2), .dout(o2), .pu(u2), .drv(drv[2:0]), .lvl(l2), .pin(n2));
    board_pins #(.W(4)) b4 (.clk(clk), .oe(e4), .dout(o4), .pu(u4), .drv(drv[3:0]), .lvl(l4), .pin(n4));
    board_pins #(.W(2)) b6 (.clk(clk), .oe(e6), .dout(o6), .pu(u6), .drv(drv[1:0]), .lvl(l6), .pin(n6));
    board_pins #(.W(6)) b8 (.clk(clk), .oe(e8), .dout(o8), .pu(u8), .drv(drv), .lvl(l8), .pin(n8));
    port_pin_mux u_dut (.CORE_CLK(clk), .NRST(nrst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PORT_ZERO_PINS_IN(n0), .PORT_ZERO_PINS_OUT(o0), .PORT_ZERO_PINS_OE(e0), .PORT_ZERO_PINS_PU(u0),
        .PORT_ONE_PINS_IN(n1), .PORT_ONE_PINS_OUT(o1), .PORT_ONE_PINS_OE(e1), .PORT_ONE_PINS_PU(u1),
        .PORT_TWO_PINS_IN(n2), .PORT_TWO_PINS_OUT(o2), .PORT_TWO_PINS_OE(e2), .PORT_TWO_PINS_PU(u2),
        .PORT_FOUR_PINS_IN(n4), .PORT_FOUR_PINS_OUT(o4), .PORT_FOUR_PINS_OE(e4), .PORT_FOUR_PINS_PU(u4),
        .PORT_SIX_PINS_IN(n6), .PORT_SIX_PINS_OUT(o6), .PORT_SIX_PINS_OE(e6), .PORT_SIX_PINS_PU(u6),
        .PORT_EIGHT_PINS_IN(n8), .PORT_EIGHT_PINS_OUT(o8), .PORT_EIGHT_PINS_OE(e8), .PORT_EIGHT_PINS_PU(u8),
        .SER_CLK_OUT(sck_o), .SER_CLK_DRIVE(sck_d), .SER_DATA_OUT(sdo), .SER_CLK_IN(sck_in), .SER_DATA_IN(sdi),
        .TIMER_FORTY_OUT(tmr), .INT_EDGE_PULSE(int_p), .KEY_RETURN_INPUTS(kin), .KEY_RETURN_PULSE(key_p),
        .LCD_SEG_DEDICATED_IN(ded_in), .LCD_SEG_LAST_IN(seg_last), .LCD_SEG_SHARED_IN(sh_in),
        .LCD_COMMON_IN(com_in), .LCD_SEG_DEDICATED(ded), .LCD_SEG_LAST(last), .LCD_COMMON_OUTS(com));
    always @(posedge clk) begin
        if (int_p === 1'b1) int_cnt++;
        if (key_p === 1'b1) key_cnt++;
    end
    task automatic report_and_stop();
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Holds the request until ack is sampled high, then releases for a cycle
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d}; sel <= 4'h1;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        r = rdat;
        if (ack !== 1'b1) chk(32'h0, 32'h1);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(a, 1'b1, d, q);
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({e0, e1, e2, e4, e6, e8}, 32'h0);
        chk({com, ded, last}, 32'h0);
        wb(OFF_PORT_ZERO_MODE, 1'b0, 8'h00, q);
        chk(q, 32'h0f);
        wb(OFF_PORT_EIGHT_MODE, 1'b0, 8'h00, q);
        chk(q, 32'h3f);
        wb(8'h80, 1'b0, 8'h00, q);
        chk(q, 32'h0);
        // Mixed directions in one port
        wr(OFF_PORT_ZERO_MODE, 8'h05);
        wr(OFF_PORT_ZERO_DATA, 8'h0a);
        chk({e0, o0}, {4'ha, 4'ha});
        wb(OFF_PORT_ZERO_DATA, 1'b0, 8'h00, q);
        chk(q, 32'h0b);
        wr(OFF_PORT_PULLUP, 8'h03);
        chk({u0, u1, u4}, {4'h5, 2'h3, 4'h0});
        // Board lets port zero float, pull-ups must lift the inputs
        d0 <= 4'h0;
        wr(OFF_PORT_ONE_MODE, 8'h00);
        wr(OFF_PORT_ONE_DATA, 8'h02);
        chk({e1, o1, u1}, {2'h3, 2'h2, 2'h0});
        wb(OFF_PORT_ZERO_DATA, 1'b0, 8'h00, q);
        chk(q, 32'h0f);
        wr(OFF_KEY_RETURN_MODE, 8'h01);
        chk({u4, e4, o4}, {4'hf, 4'h0, 4'h0});
        c0 = key_cnt;
        l4 <= 4'hb;
        repeat (4) @(posedge clk);
        chk(key_cnt - c0, 1);
        chk(kin, 4'hb);
        wr(OFF_SERIAL_PULLUP, 8'h05);
        chk(u2, 3'h5);
        chk(sck_in, 1'b0);
        wr(OFF_ALT_CTRL, 8'h12);
        chk({e6[0], o6[0]}, 2'h3);
        chk({com, ded, last}, {com_in, ded_in, seg_last});
        for (int e = 0; e < 4; e++) begin
            wr(OFF_ALT_CTRL, 8'h12 | 8'(e << ALT_EDGE_LSB));
            c0 = int_cnt;
            l6 <= 2'h2;
            repeat (4) @(posedge clk);
            l6 <= 2'h0;
            repeat (4) @(posedge clk);
            chk(int_cnt - c0, edge_exp[e]);
        end
        // Serial takes port two over without any mode setup
        wr(OFF_ALT_CTRL, 8'h13);
        chk({e2, o2[1:0], u2}, {3'h3, 2'h1, 3'h4});
        chk(sdi, 1'b1);
        chk(sck_in, 1'b1);
        wr(OFF_PORT_EIGHT_FUNC, 8'h21);
        chk({e8, o8}, {6'h21, 6'h20});
        wr(OFF_PORT_EIGHT_MODE, 8'h3d);
        wr(OFF_PORT_EIGHT_DATA, 8'h02);
        chk({e8, o8[1]}, {6'h23, 1'b1});
        chk({u6, u8}, 8'h00);
        // Reset in mid-run must drop every configured drive
        nrst_n <= 1'b0;
        repeat (2) @(posedge clk);
        nrst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({e0, e1, e2, e4, e6, e8}, 32'h0);
        chk({com, ded, last}, 32'h0);
        report_and_stop();
    end
endmodule
